// ---- hw/dim_pkg.sv ----
package dim_pkg;
  // ==========================================
  // Terminals
  localparam int NUM_TERM = 9;
  localparam int T18 = 0;
  localparam int T19 = 1;
  localparam int T27 = 2;
  localparam int T29 = 3;
  localparam int T32 = 4;
  localparam int T33 = 5;
  localparam int EXT_A = 6;
  localparam int EXT_B = 7;
  localparam int EXT_C = 8;
  // ==========================================
  // Function codes
  localparam logic [7:0] FN_NOP = 8'h00;
  localparam logic [7:0] FN_RESET = 8'h01;
  localparam logic [7:0] FN_STOP_INV = 8'h06;
  localparam logic [7:0] FN_START = 8'h08;
  localparam logic [7:0] FN_LATCH = 8'h09;
  localparam logic [7:0] FN_SETUP_B0 = 8'h17;
  localparam logic [7:0] FN_SETUP_B1 = 8'h18;
  localparam logic [7:0] FN_PULSE = 8'h20;
  localparam logic [7:0] FN_FOLLOW1 = 8'h63;
  localparam logic [7:0] FN_FOLLOW2 = 8'h64;
  localparam logic [7:0] FN_SLEEP = 8'h65;
  localparam logic FN_STO_OFF = 1'h0;
  localparam logic FN_STO_ON = 1'h1;
  // ==========================================
  // Register offsets
  localparam logic [7:0] ADDR_FSEL0 = 8'h00;
  localparam logic [7:0] ADDR_FSEL1 = 8'h04;
  localparam logic [7:0] ADDR_FSEL2 = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_PER29 = 8'h1C;
  localparam logic [7:0] ADDR_PER33 = 8'h20;
  // ==========================================
  // Field positions
  localparam int FSEL2_STO_BIT = 8;
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_APPLY_BIT = 1;
  localparam int CTRL_DIR27_BIT = 2;
  localparam int CTRL_DIR29_BIT = 3;
  localparam int CTRL_MULTI_BIT = 4;
  localparam int CTRL_PAR_BIT = 5;
  localparam int ST_SETUP_LSB = 0;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_LATCH_BIT = 3;
  localparam int ST_POL_BIT = 4;
  localparam int ST_STO_BIT = 5;
  localparam int ST_SLEEP_BIT = 6;
  localparam int ST_LEVEL_LSB = 16;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_SLEEP = 2;
  localparam int IRQ_PULSE = 3;
  localparam int IRQ_STO = 4;
  localparam int IRQ_REJECT = 5;
  localparam int IRQ_W = 6;
  // ==========================================
  // Reset values
  localparam logic [7:0] FSEL_RST_T18 = FN_START;
  localparam logic [7:0] FSEL_RST_T32 = FN_SETUP_B1;
  localparam logic [7:0] FSEL_RST_OTHER = FN_NOP;
  localparam logic FSEL_RST_STO = FN_STO_ON;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
  // ==========================================
  // Timing
  localparam int CLK_FREQ_MHZ = 50;
  localparam int LATCH_MIN_US = 2000;
  localparam int LATCH_MIN_CYCLES = LATCH_MIN_US * CLK_FREQ_MHZ;
  localparam int PERIOD_W = 24;
  // ==========================================
  // Latched start state
  typedef enum logic [0:0] {
    DIM_LS_STOP = 1'b0,
    DIM_LS_RUN = 1'b1
  } dim_latch_e;
endpackage

// ---- hw/dim_input_channel.sv ----
`timescale 1ns/100ps
module dim_input_channel #(
  parameter int LATCH_CYCLES = dim_pkg::LATCH_MIN_CYCLES,
  parameter bit HAS_PERIOD = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic invert_i,
  input wire logic period_en_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o,
  output logic latch_o,
  output logic period_stb_o,
  output logic [dim_pkg::PERIOD_W-1:0] period_o
);
  localparam int CW = $clog2(LATCH_CYCLES + 1);
  localparam int PW = dim_pkg::PERIOD_W;
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic [CW-1:0] hold_ff;

  // ==========================================
  // Synchroniser and edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end

  assign level_o = sync_ff ^ invert_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level_o;
    end
  end

  assign rise_o = level_o & ~prev_ff;
  assign fall_o = ~level_o & prev_ff;

  // ==========================================
  // Pulse width timer
  always_ff @(posedge clk_i) begin
    if (rst_i || !level_o) begin
      hold_ff <= '0;
    end else if (hold_ff != CW'(LATCH_CYCLES)) begin
      hold_ff <= hold_ff + 1'b1;
    end
  end

  assign latch_o = level_o && (hold_ff == CW'(LATCH_CYCLES - 1));

  // ==========================================
  // Edge to edge period
  generate
    if (HAS_PERIOD) begin : g_per
      logic [PW-1:0] cnt_ff;
      logic [PW-1:0] per_ff;
      logic seen_ff;
      logic stb_ff;
      always_ff @(posedge clk_i) begin
        if (rst_i || !period_en_i) begin
          cnt_ff <= '0;
          per_ff <= '0;
          seen_ff <= 1'b0;
          stb_ff <= 1'b0;
        end else begin
          stb_ff <= rise_o && seen_ff;
          if (rise_o) begin
            seen_ff <= 1'b1;
            cnt_ff <= PW'(1);
            if (seen_ff) begin
              per_ff <= cnt_ff;
            end
          end else if (cnt_ff != '1) begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      end
      assign period_o = per_ff;
      assign period_stb_o = stb_ff;
    end else begin : g_noper
      assign period_o = '0;
      assign period_stb_o = 1'b0;
    end
  endgenerate
endmodule

// ---- hw/dim_digital_input_mapper.sv ----
`timescale 1ns/100ps
// Operation
// - Code 0 gives the terminal no function; its level still shows in status.
// - Code 1 requests trip clear, except non-resettable.
// - Code 6 stops on one-to-zero change.
// - Code 8 follows level: one run, zero stop.
// - First standard terminal resets to code 8.
// - Code 9 latches run after 2 ms.
// - Codes 23/24 pick set-up in multi mode.
// - Terminal 32 resets to code 24.
// - Code 32 measures time between rising edges.
// - Code 32 only on two pulse terminals.
// - Codes 99/100 follower feedback, device assigned.
// - Code 101 sleeps; front four terminals only.
// - Other terminals reset to code 0.
// - Torque off terminal defaults on, raises alarm.
// - Polarity setting applies only on a control write with the apply bit set.
// - Two terminals switchable to output, not running.
module dim_digital_input_mapper #(
  parameter int LATCH_CYCLES = dim_pkg::LATCH_MIN_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic term18_i,
  input wire logic term19_i,
  input wire logic term27_i,
  input wire logic term29_i,
  input wire logic term32_i,
  input wire logic term33_i,
  input wire logic extension_input_a_i,
  input wire logic extension_input_b_i,
  input wire logic extension_input_c_i,
  input wire logic safe_torque_off_input_i,
  input wire logic unit_running_i,
  input wire logic alarm_nonresettable_i,
  output logic run_cmd_o,
  output logic stop_req_o,
  output logic trip_clear_o,
  output logic sleep_req_o,
  output logic [1:0] setup_idx_o,
  output logic follower1_run_o,
  output logic follower2_run_o,
  output logic sto_torque_off_o,
  output logic term27_is_output_o,
  output logic term29_is_output_o,
  output logic irq_o
);
  localparam int N = dim_pkg::NUM_TERM;
  localparam int PW = dim_pkg::PERIOD_W;
  localparam int IW = dim_pkg::IRQ_W;

  logic [N-1:0] pins;
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] lat;
  logic [N-1:0] pstb;
  logic [PW-1:0] per [N];
  logic [7:0] fsel_ff [N];
  logic [7:0] eff [N];
  logic [N-1:0] wr_hit;
  logic [7:0] wr_code [N];
  logic [N-1:0] wr_ok;
  logic sto_fn_ff;
  logic [5:0] ctrl_ff;
  logic pol_act_ff;
  logic [IW-1:0] irq_stat_ff;
  logic [IW-1:0] irq_mask_ff;
  logic [IW-1:0] irq_evt;
  logic sto_meta_ff;
  logic sto_sync_ff;
  logic sto_prev_ff;
  dim_pkg::dim_latch_e ls_ff;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rd_data;
  logic run_lvl;
  logic stop_evt;
  logic trip_evt;
  logic sleep_lvl;
  logic latch_evt;
  logic [1:0] setup_bits;
  logic fol1;
  logic fol2;
  logic sto_on;
  logic [1:0] nxt_setup;

  assign pins = {extension_input_c_i, extension_input_b_i, extension_input_a_i, term33_i, term32_i,
                 term29_i, term27_i, term19_i, term18_i};

  // ==========================================
  // Input channels
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ch
      dim_input_channel #(
        .LATCH_CYCLES(LATCH_CYCLES),
        .HAS_PERIOD(gi == dim_pkg::T29 || gi == dim_pkg::T33)
      ) u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pins[gi]),
        .invert_i(pol_act_ff),
        .period_en_i(eff[gi] == dim_pkg::FN_PULSE),
        .level_o(lvl[gi]),
        .rise_o(rise[gi]),
        .fall_o(fall[gi]),
        .latch_o(lat[gi]),
        .period_stb_o(pstb[gi]),
        .period_o(per[gi])
      );
    end
  endgenerate

  // ==========================================
  // Selector checks
  function automatic logic code_ok(input int idx, input logic [7:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      dim_pkg::FN_NOP, dim_pkg::FN_RESET, dim_pkg::FN_STOP_INV, dim_pkg::FN_START,
      dim_pkg::FN_LATCH, dim_pkg::FN_SETUP_B0, dim_pkg::FN_SETUP_B1: begin
        ok = 1'b1;
      end
      dim_pkg::FN_PULSE: begin
        ok = (idx == dim_pkg::T29) || (idx == dim_pkg::T33);
      end
      dim_pkg::FN_SLEEP: begin
        ok = idx <= dim_pkg::T29;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      wr_hit[i] = wr_stb && (wb_adr_i == 8'(dim_pkg::ADDR_FSEL0 + 4 * (i / 4))) && wb_sel_i[i % 4];
      wr_code[i] = wb_dat_i[8 * (i % 4) +: 8];
      wr_ok[i] = code_ok(i, wr_code[i]);
    end
  end

  // ==========================================
  // Function selectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        fsel_ff[i] <= dim_pkg::FSEL_RST_OTHER;
      end
      fsel_ff[dim_pkg::T18] <= dim_pkg::FSEL_RST_T18;
      fsel_ff[dim_pkg::T32] <= dim_pkg::FSEL_RST_T32;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_hit[i] && wr_ok[i]) begin
          fsel_ff[i] <= wr_code[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sto_fn_ff <= dim_pkg::FSEL_RST_STO;
    end else if (wr_stb && wb_adr_i == dim_pkg::ADDR_FSEL2 && wb_sel_i[1]) begin
      sto_fn_ff <= wb_dat_i[dim_pkg::FSEL2_STO_BIT];
    end
  end

  // ==========================================
  // Control and polarity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= dim_pkg::CTRL_RST;
    end else if (wr_stb && wb_adr_i == dim_pkg::ADDR_CTRL && wb_sel_i[0]) begin
      ctrl_ff[dim_pkg::CTRL_POL_BIT] <= wb_dat_i[dim_pkg::CTRL_POL_BIT];
      ctrl_ff[dim_pkg::CTRL_MULTI_BIT] <= wb_dat_i[dim_pkg::CTRL_MULTI_BIT];
      ctrl_ff[dim_pkg::CTRL_PAR_BIT] <= wb_dat_i[dim_pkg::CTRL_PAR_BIT];
      if (!unit_running_i) begin
        ctrl_ff[dim_pkg::CTRL_DIR27_BIT] <= wb_dat_i[dim_pkg::CTRL_DIR27_BIT];
        ctrl_ff[dim_pkg::CTRL_DIR29_BIT] <= wb_dat_i[dim_pkg::CTRL_DIR29_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_act_ff <= 1'b0;
    end else if (wr_stb && wb_adr_i == dim_pkg::ADDR_CTRL && wb_sel_i[0] &&
                 wb_dat_i[dim_pkg::CTRL_APPLY_BIT]) begin
      pol_act_ff <= ctrl_ff[dim_pkg::CTRL_POL_BIT];
    end
  end

  // ==========================================
  // Effective function per terminal
  always_comb begin
    for (int i = 0; i < N; i++) begin
      eff[i] = fsel_ff[i];
    end
    if (ctrl_ff[dim_pkg::CTRL_PAR_BIT]) begin
      eff[dim_pkg::EXT_A] = dim_pkg::FN_FOLLOW1;
      eff[dim_pkg::EXT_B] = dim_pkg::FN_FOLLOW2;
    end
    if (ctrl_ff[dim_pkg::CTRL_DIR27_BIT]) begin
      eff[dim_pkg::T27] = dim_pkg::FN_NOP;
    end
    if (ctrl_ff[dim_pkg::CTRL_DIR29_BIT]) begin
      eff[dim_pkg::T29] = dim_pkg::FN_NOP;
    end
  end

  // ==========================================
  // Function decode
  always_comb begin
    run_lvl = 1'b0;
    stop_evt = 1'b0;
    trip_evt = 1'b0;
    sleep_lvl = 1'b0;
    latch_evt = 1'b0;
    setup_bits = 2'h0;
    fol1 = 1'b0;
    fol2 = 1'b0;
    for (int i = 0; i < N; i++) begin
      case (eff[i])
        dim_pkg::FN_RESET: trip_evt = trip_evt | rise[i];
        dim_pkg::FN_STOP_INV: stop_evt = stop_evt | fall[i];
        dim_pkg::FN_START: run_lvl = run_lvl | lvl[i];
        dim_pkg::FN_LATCH: latch_evt = latch_evt | lat[i];
        dim_pkg::FN_SETUP_B0: setup_bits[0] = setup_bits[0] | lvl[i];
        dim_pkg::FN_SETUP_B1: setup_bits[1] = setup_bits[1] | lvl[i];
        dim_pkg::FN_FOLLOW1: fol1 = fol1 | lvl[i];
        dim_pkg::FN_FOLLOW2: fol2 = fol2 | lvl[i];
        dim_pkg::FN_SLEEP: sleep_lvl = sleep_lvl | lvl[i];
        default: begin
        end
      endcase
    end
  end

  assign nxt_setup = ctrl_ff[dim_pkg::CTRL_MULTI_BIT] ? setup_bits : 2'h0;

  // ==========================================
  // Latched start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_ff <= dim_pkg::DIM_LS_STOP;
    end else begin
      case (ls_ff)
        dim_pkg::DIM_LS_STOP: begin
          if (latch_evt && !stop_evt) begin
            ls_ff <= dim_pkg::DIM_LS_RUN;
          end
        end
        dim_pkg::DIM_LS_RUN: begin
          if (stop_evt) begin
            ls_ff <= dim_pkg::DIM_LS_STOP;
          end
        end
        default: ls_ff <= dim_pkg::DIM_LS_STOP;
      endcase
    end
  end

  // ==========================================
  // Safe torque off terminal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sto_meta_ff <= 1'b1;
      sto_sync_ff <= 1'b1;
      sto_prev_ff <= 1'b0;
    end else begin
      sto_meta_ff <= safe_torque_off_input_i;
      sto_sync_ff <= sto_meta_ff;
      sto_prev_ff <= sto_on;
    end
  end

  assign sto_on = (sto_fn_ff == dim_pkg::FN_STO_ON) && !sto_sync_ff;

  // ==========================================
  // Request outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_cmd_o <= 1'b0;
      stop_req_o <= 1'b0;
      trip_clear_o <= 1'b0;
      sleep_req_o <= 1'b0;
      setup_idx_o <= 2'h0;
      follower1_run_o <= 1'b0;
      follower2_run_o <= 1'b0;
      sto_torque_off_o <= 1'b0;
      term27_is_output_o <= 1'b0;
      term29_is_output_o <= 1'b0;
    end else begin
      run_cmd_o <= (run_lvl || ls_ff == dim_pkg::DIM_LS_RUN) && !stop_evt;
      stop_req_o <= stop_evt;
      trip_clear_o <= trip_evt && !alarm_nonresettable_i;
      sleep_req_o <= sleep_lvl;
      setup_idx_o <= nxt_setup;
      follower1_run_o <= fol1;
      follower2_run_o <= fol2;
      sto_torque_off_o <= sto_on;
      term27_is_output_o <= ctrl_ff[dim_pkg::CTRL_DIR27_BIT];
      term29_is_output_o <= ctrl_ff[dim_pkg::CTRL_DIR29_BIT];
    end
  end

  // ==========================================
  // Interrupts
  always_comb begin
    irq_evt = '0;
    irq_evt[dim_pkg::IRQ_TRIP] = trip_evt;
    irq_evt[dim_pkg::IRQ_STOP] = stop_evt;
    irq_evt[dim_pkg::IRQ_SLEEP] = sleep_lvl && !sleep_req_o;
    irq_evt[dim_pkg::IRQ_PULSE] = |pstb;
    irq_evt[dim_pkg::IRQ_STO] = sto_on && !sto_prev_ff;
    irq_evt[dim_pkg::IRQ_REJECT] = |(wr_hit & ~wr_ok);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else if (wr_stb && wb_adr_i == dim_pkg::ADDR_IRQ_STAT && wb_sel_i[0]) begin
      irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[IW-1:0]) | irq_evt;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= dim_pkg::IRQ_MASK_RST;
    end else if (wr_stb && wb_adr_i == dim_pkg::ADDR_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask_ff <= wb_dat_i[IW-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ==========================================
  // Wishbone read and acknowledge
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      dim_pkg::ADDR_FSEL0: rd_data = {fsel_ff[3], fsel_ff[2], fsel_ff[1], fsel_ff[0]};
      dim_pkg::ADDR_FSEL1: rd_data = {fsel_ff[7], fsel_ff[6], fsel_ff[5], fsel_ff[4]};
      dim_pkg::ADDR_FSEL2: begin
        rd_data[7:0] = fsel_ff[8];
        rd_data[dim_pkg::FSEL2_STO_BIT] = sto_fn_ff;
      end
      dim_pkg::ADDR_CTRL: rd_data[5:0] = ctrl_ff;
      dim_pkg::ADDR_STATUS: begin
        rd_data[dim_pkg::ST_SETUP_LSB +: 2] = setup_idx_o;
        rd_data[dim_pkg::ST_RUN_BIT] = run_cmd_o;
        rd_data[dim_pkg::ST_LATCH_BIT] = ls_ff == dim_pkg::DIM_LS_RUN;
        rd_data[dim_pkg::ST_POL_BIT] = pol_act_ff;
        rd_data[dim_pkg::ST_STO_BIT] = sto_torque_off_o;
        rd_data[dim_pkg::ST_SLEEP_BIT] = sleep_req_o;
        rd_data[dim_pkg::ST_LEVEL_LSB +: N] = lvl;
      end
      dim_pkg::ADDR_IRQ_STAT: rd_data[IW-1:0] = irq_stat_ff;
      dim_pkg::ADDR_IRQ_MASK: rd_data[IW-1:0] = irq_mask_ff;
      dim_pkg::ADDR_PER29: rd_data[PW-1:0] = per[dim_pkg::T29];
      dim_pkg::ADDR_PER33: rd_data[PW-1:0] = per[dim_pkg::T33];
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (rd_stb) begin
        wb_dat_o <= rd_data;
      end
    end
  end
endmodule

// ---- verification/dim_switch_model.sv ----
`timescale 1ns/100ps
// ==========================================
// External switches on the input terminals
module dim_switch_model (
  input wire logic clk_i,
  output logic [9:0] pins_o
);
  // Idle: inputs low, torque-off pin high
  initial pins_o = 10'h200;
  // Caller sits on a rising edge
  task automatic put(input int idx, input logic v);
    pins_o[idx] <= v;
  endtask
  // Press held for n cycles, then released
  task automatic press(input int idx, input int n);
    pins_o[idx] <= 1'b1;
    repeat (n) @(posedge clk_i);
    pins_o[idx] <= 1'b0;
  endtask
endmodule

// ---- verification/dim_mapper_asserts.sv ----
`timescale 1ns/100ps
// ==========================================
// Port checker
module dim_mapper_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic safe_torque_off_input_i,
  input wire logic unit_running_i,
  input wire logic alarm_nonresettable_i,
  input wire logic stop_req_o,
  input wire logic trip_clear_o,
  input wire logic sto_torque_off_o,
  input wire logic term27_is_output_o,
  input wire logic term29_is_output_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_unmapped;
    s_req ##0 (!wb_we_i && wb_adr_i >= 8'h24);
  endsequence
  AST_ACK_NEXT:
    assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_UNMAPPED_ZERO:
    assert property (s_rd_unmapped |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  AST_STOP_PULSE:
    assert property (stop_req_o |=> !stop_req_o) else $error("stop request not a pulse");
  AST_TRIP_PULSE:
    assert property (trip_clear_o |=> !trip_clear_o) else $error("trip clear not a pulse");
  AST_TRIP_BLOCK:
    assert property (alarm_nonresettable_i && $past(alarm_nonresettable_i) |-> !trip_clear_o)
      else $error("trip clear with locked alarm");
  AST_DIR_FROZEN:
    assert property (unit_running_i [*3] |-> $stable(term27_is_output_o) && $stable(term29_is_output_o))
      else $error("direction changed while running");
  AST_STO_RELEASE:
    assert property (safe_torque_off_input_i [*5] |-> !sto_torque_off_o) else $error("torque off with pin high");
  AST_STO_SYNC:
    assert property ($rose(sto_torque_off_o) |-> !$past(safe_torque_off_input_i, 3))
      else $error("torque off faster than synchroniser");
endmodule
bind dim_digital_input_mapper dim_mapper_asserts u_chk (.*);

// ---- verification/test_dim_digital_input_mapper.sv ----
`timescale 1ns/100ps
// ==========================================
// Testbench
module test_dim_digital_input_mapper;
  localparam int LC = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic running = 1'b0;
  logic alarm = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, run, stop, trip, sleep, f1, f2, safe_torque_off_input, d27, d29, irq;
  logic [1:0] setup;
  logic [9:0] pins;
  logic [8:0] o;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_stop = 0;
  int n_trip = 0;
  dim_switch_model sw (.clk_i(clk_i), .pins_o(pins));
  dim_digital_input_mapper #(.LATCH_CYCLES(LC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .term18_i(pins[0]), .term19_i(pins[1]), .term27_i(pins[2]), .term29_i(pins[3]),
    .term32_i(pins[4]), .term33_i(pins[5]), .extension_input_a_i(pins[6]),
    .extension_input_b_i(pins[7]), .extension_input_c_i(pins[8]), .safe_torque_off_input_i(pins[9]),
    .unit_running_i(running), .alarm_nonresettable_i(alarm), .run_cmd_o(run), .stop_req_o(stop),
    .trip_clear_o(trip), .sleep_req_o(sleep), .setup_idx_o(setup), .follower1_run_o(f1),
    .follower2_run_o(f2), .sto_torque_off_o(safe_torque_off_input), .term27_is_output_o(d27),
    .term29_is_output_o(d29), .irq_o(irq));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ==========================================
  // Settled samples of the outputs
  always @(negedge clk_i) begin
    o <= {f2, f1, irq, d27, safe_torque_off_input, setup, sleep, run};
    n_stop <= n_stop + int'(stop);
    n_trip <= n_trip + int'(trip);
  end
  // ==========================================
  // Tasks
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      chk("ack", 32'h1, 32'(ack));
      end_of_test();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ==========================================
  // Sequence
  initial begin
    w(20);
    rst_i <= 1'b0;
    w(4);
    rdchk(8'h00, 32'h00000008);
    rdchk(8'h04, 32'h00000018);
    rdchk(8'h08, 32'h00000100);
    rdchk(8'hFC, 32'h0);
    sw.put(1, 1'b1);
    sw.put(0, 1'b1);
    w(6);
    chk("run", 1'b1, o[0]);
    sw.put(1, 1'b0);
    sw.put(0, 1'b0);
    w(6);
    chk("run", 1'b0, o[0]);
    chk("stops", 0, n_stop);
    wb(1'b1, 8'h00, 32'h00000608);
    wb(1'b1, 8'h18, 32'h2);
    sw.press(1, 6);
    w(6);
    chk("stops", 1, n_stop);
    chk("irq", 1'b1, o[6]);
    rdchk(8'h14, 32'h2);
    wb(1'b1, 8'h14, 32'h2);
    wb(1'b1, 8'h18, 32'h0);
    sw.press(1, 6);
    w(6);
    chk("irq", 1'b0, o[6]);
    rdchk(8'h14, 32'h2);
    wb(1'b1, 8'h00, 32'h00090608);
    sw.press(2, 3);
    w(6);
    chk("run", 1'b0, o[0]);
    sw.press(2, LC + 4);
    w(6);
    chk("run", 1'b1, o[0]);
    sw.press(1, 6);
    w(6);
    chk("run", 1'b0, o[0]);
    wb(1'b1, 8'h00, 32'h01090608);
    sw.press(3, 6);
    w(6);
    chk("trips", 1, n_trip);
    alarm <= 1'b1;
    sw.press(3, 6);
    w(6);
    alarm <= 1'b0;
    chk("trips", 1, n_trip);
    wb(1'b1, 8'h14, 32'h3F);
    wb(1'b1, 8'h04, 32'h00000020);
    rdchk(8'h04, 32'h00000018);
    wb(1'b1, 8'h04, 32'h00000063);
    rdchk(8'h04, 32'h00000018);
    wb(1'b1, 8'h04, 32'h00000064);
    rdchk(8'h04, 32'h00000018);
    wb(1'b1, 8'h04, 32'h00000065);
    rdchk(8'h04, 32'h00000018);
    rdchk(8'h14, 32'h20);
    wb(1'b1, 8'h00, 32'h20090608);
    for (int k = 0; k < 8; k++) begin
      sw.put(3, k % 2 == 0);
      w(5);
    end
    rdchk(8'h1C, 32'd10);
    rdchk(8'h14, 32'h28);
    wb(1'b1, 8'h04, 32'h18170000);
    sw.put(6, 1'b1);
    sw.put(7, 1'b1);
    w(6);
    chk("setup", 2'd0, o[3:2]);
    wb(1'b1, 8'h0C, 32'h10);
    w(3);
    chk("setup", 2'd3, o[3:2]);
    sw.put(7, 1'b0);
    w(6);
    chk("setup", 2'd1, o[3:2]);
    wb(1'b1, 8'h00, 32'h20096508);
    sw.put(1, 1'b1);
    w(6);
    chk("sleep", 1'b1, o[1]);
    wb(1'b1, 8'h0C, 32'h30);
    w(2);
    chk("follower1", 1'b1, o[7]);
    chk("follower2", 1'b0, o[8]);
    sw.put(7, 1'b1);
    w(6);
    chk("follower2", 1'b1, o[8]);
    sw.put(9, 1'b0);
    w(6);
    chk("sto", 1'b1, o[4]);
    wb(1'b1, 8'h08, 32'h0);
    w(3);
    chk("sto", 1'b0, o[4]);
    running <= 1'b1;
    wb(1'b1, 8'h0C, 32'h1C);
    w(2);
    chk("dir27", 1'b0, o[5]);
    running <= 1'b0;
    wb(1'b1, 8'h0C, 32'h1C);
    w(2);
    chk("dir27", 1'b1, o[5]);
    wb(1'b1, 8'h0C, 32'h1D);
    wb(1'b0, 8'h10, 32'h0);
    chk("polarity", 1'b0, rdat[4]);
    wb(1'b1, 8'h0C, 32'h1F);
    wb(1'b0, 8'h10, 32'h0);
    chk("polarity", 1'b1, rdat[4]);
    end_of_test();
  end
endmodule
